//--- bench/id_link_asserts.sv
// Link protocol and identification value checks
`timescale 1ns/1ps
`default_nettype none
module id_link_asserts
  import id_regs_pkg::*;
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  // Link signals
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_priv,
  input wire logic        req_nonsecure,
  input wire logic [2:0]  req_opc1,
  input wire logic [3:0]  req_crn,
  input wire logic [3:0]  req_crm,
  input wire logic [2:0]  req_opc2,
  input wire logic [31:0] req_wdata,
  input wire logic        rsp_ack,
  input wire logic        rsp_undef,
  input wire logic [31:0] rsp_rdata
);
  localparam logic [15:0] K_ISA3 = {2'b01, OPC1_ISA, CRN_ID, CRM_ISA,
                                    OPC2_ISA3};
  localparam logic [15:0] K_ISA4 = {2'b01, OPC1_ISA, CRN_ID, CRM_ISA,
                                    OPC2_ISA4};
  localparam logic [15:0] K_ISA5 = {2'b01, OPC1_ISA, CRN_ID, CRM_ISA,
                                    OPC2_ISA5};
  localparam logic [15:0] K_LVL  = {2'b01, OPC1_CACHE, CRN_ID, CRM_CACHE,
                                    OPC2_LEVEL};
  logic [15:0] key_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // Request as taken, judged against the answer a cycle on
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      key_q <= 16'h0000;
    else if (req_valid)
      key_q <= {req_write, req_priv, req_opc1, req_crn, req_crm, req_opc2};
  end

  a_req_answered: assert property ($rose(req_valid) |=> rsp_ack)
    else $error("link request not answered in one cycle");
  a_ack_single: assert property (rsp_ack |=> !rsp_ack)
    else $error("link ack longer than one cycle");
  a_attr3_value: assert property (rsp_ack && key_q == K_ISA3 |->
    !rsp_undef && (rsp_rdata & 32'hffff_ff0f) == 32'h1111_2101)
    else $error("attribute 3 value wrong");
  a_attr4_value: assert property (rsp_ack && key_q == K_ISA4 |->
    !rsp_undef && rsp_rdata == 32'h1001_1142)
    else $error("attribute 4 value wrong");
  a_attr5_zero: assert property (
    rsp_ack && key_q[14:0] == K_ISA5[14:0] |->
    !rsp_undef && rsp_rdata == 32'h0000_0000)
    else $error("attribute 5 not zero or refused");
  a_level_value: assert property (rsp_ack && key_q == K_LVL |->
    !rsp_undef && rsp_rdata == 32'h0a20_0023)
    else $error("cache level value wrong");
  a_unpriv_undef: assert property (rsp_ack && !key_q[14] |->
    rsp_undef && rsp_rdata == 32'h0000_0000)
    else $error("unprivileged access not refused");
  a_ro_write_undef: assert property (rsp_ack && key_q[15] &&
    key_q[13:11] == OPC1_CACHE |-> rsp_undef)
    else $error("write to cache info not refused");

  c_refused: cover property (rsp_ack && rsp_undef);
  c_answered: cover property (rsp_ack && !rsp_undef);
  c_started: cover property ($rose(req_valid));
endmodule // id_link_asserts
`default_nettype wire

//--- bench/isa_and_cache_id_registers_tb.sv
// Testbench joining the APB controller and the identification registers
`timescale 1ns/1ps
`default_nettype none
module isa_and_cache_id_registers_tb
  import id_regs_pkg::*;
;
  localparam logic [15:0] K_ISA3 = {2'b01, OPC1_ISA, CRN_ID, CRM_ISA,
                                    OPC2_ISA3};
  localparam logic [15:0] K_ISA4 = {2'b01, OPC1_ISA, CRN_ID, CRM_ISA,
                                    OPC2_ISA4};
  localparam logic [15:0] K_ISA5 = {2'b01, OPC1_ISA, CRN_ID, CRM_ISA,
                                    OPC2_ISA5};
  localparam logic [15:0] K_SIZE = {2'b01, OPC1_CACHE, CRN_ID, CRM_CACHE,
                                    OPC2_SIZE};
  localparam logic [15:0] K_LVL  = K_SIZE | 16'h0001;
  localparam logic [15:0] K_SEL  = {2'b01, OPC1_SEL, CRN_ID, CRM_CACHE,
                                    OPC2_SEL};
  localparam logic [64:0] UNDEF  = {1'b1, 32'hffff_ffff, 32'h0};
  logic        clock_i;
  logic        sys_rst_i;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, lfsr_q;
  logic [1:0]  l2_size;
  logic [64:0] ent;
  logic [64:0] exp_q[$];
  logic [15:0] ro_keys[4];
  logic [31:0] l2_tab[4];
  int          failures;
  int          total_checks;

  cp_link_if link ();
  core_id_ctrl core_id_ctrl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr),
    .prdata_o(prdata), .link(link));
  isa_cache_id_regs isa_cache_id_regs_i (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .l2_size_i(l2_size), .link(link));
  id_link_asserts id_link_asserts_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .req_valid(link.req_valid), .req_write(link.req_write),
    .req_priv(link.req_priv), .req_nonsecure(link.req_nonsecure),
    .req_opc1(link.req_opc1), .req_crn(link.req_crn),
    .req_crm(link.req_crm), .req_opc2(link.req_opc2),
    .req_wdata(link.req_wdata), .rsp_ack(link.rsp_ack),
    .rsp_undef(link.rsp_undef), .rsp_rdata(link.rsp_rdata));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [64:0] good(input logic [31:0] d);
    return {1'b0, 32'hffff_ffff, d};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Leading edge keeps back-to-back calls from driving psel twice at once
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // Bound used up without an answer
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic access(input logic [15:0] k, input logic ns,
                        input logic [31:0] wd, input logic [64:0] exp);
    logic [31:0] rd;
    logic [31:0] st;
    logic        err;
    int          n;
    exp_q.push_back(exp);
    apb(1'b1, {28'h0, APB_WDATA}, wd, rd, err);
    apb(1'b1, {28'h0, APB_CMD}, {13'h0, k[2:0], k[6:3], k[10:7], 1'b0,
        k[13:11], 1'b0, ns, k[14], k[15]}, rd, err);
    n = 0;
    do begin
      apb(1'b0, {28'h0, APB_STATUS}, 32'h0, st, err);
      n++;
    end while (st[STAT_DONE] !== 1'b1 && n < 20);
    if (st[STAT_DONE] !== 1'b1) begin
      failures++;
      wrap_up();
    end
    chk("status undef", {31'h0, exp[64]}, {31'h0, st[STAT_UNDEF]});
    chk("pslverr low", 32'h0, {31'h0, err});
    if (!k[15]) begin
      apb(1'b0, {28'h0, APB_RDATA}, 32'h0, rd, err);
      chk("apb rdata", exp[31:0] & exp[63:32], rd & exp[63:32]);
    end
  endtask

  // Each answer on the link is matched with the oldest expectation
  always @(posedge clock_i) begin
    if (!sys_rst_i && link.rsp_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected ack", 32'h0, 32'h1);
      end else begin
        ent = exp_q.pop_front();
        chk("link rdata", ent[31:0] & ent[63:32], link.rsp_rdata & ent[63:32]);
        chk("link undef", {31'h0, ent[64]}, {31'h0, link.rsp_undef});
      end
    end
  end

  initial begin
    logic [31:0] rd;
    logic        err;
    sys_rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    l2_size = 2'h0;
    lfsr_q = 32'h1954;
    failures = 0;
    total_checks = 0;
    ro_keys = '{K_ISA3, K_ISA4, K_SIZE, K_LVL};
    l2_tab = '{32'h703f_e07a, 32'h707f_e07a, 32'h70ff_e07a, 32'h71ff_e07a};
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    access(K_ISA3, 1'b0, 32'h0, {1'b0, 32'hffff_ff0f, 32'h1111_2101});
    access(K_ISA4, 1'b0, 32'h0, good(32'h1001_1142));
    access(K_LVL, 1'b0, 32'h0, good(32'h0a20_0023));
    lfsr_q = next_rand(lfsr_q);
    access(K_ISA5 | 16'h8000, 1'b0, lfsr_q, good(32'h0));
    access(K_ISA5, 1'b0, 32'h0, good(32'h0));
    for (int i = 0; i < 4; i++) begin
      lfsr_q = next_rand(lfsr_q);
      access(ro_keys[i] | 16'h8000, 1'b0, lfsr_q, UNDEF);
      access(ro_keys[i] & 16'hbfff, 1'b0, 32'h0, UNDEF);
    end
    access(K_ISA3 | 16'h0007, 1'b0, 32'h0, UNDEF);
    access(K_SEL | 16'h8000, 1'b0, {28'h0, SEL_L1_DATA}, good(32'h0));
    access(K_SIZE, 1'b0, 32'h0, good(32'h701f_e00a));
    access(K_SEL | 16'h8000, 1'b0, {28'h0, SEL_L1_INSTR}, good(32'h0));
    access(K_SIZE, 1'b0, 32'h0, good(32'h201f_e00a));
    access(K_SEL | 16'h8000, 1'b0, {28'h0, SEL_L2}, good(32'h0));
    for (int i = 0; i < 4; i++) begin
      l2_size <= 2'(i);
      repeat (4) @(posedge clock_i);
      access(K_SIZE, 1'b0, 32'h0, good(l2_tab[i]));
    end
    for (int i = 0; i < 3; i++) begin
      lfsr_q = next_rand(lfsr_q);
      access(K_SEL | 16'h8000, 1'b0, 32'h3 + lfsr_q % 13, good(32'h0));
      access(K_SIZE, 1'b0, 32'h0, good(32'h0));
    end
    access(K_SEL | 16'h8000, 1'b1, {28'h0, SEL_L1_INSTR}, good(32'h0));
    access(K_SEL | 16'h8000, 1'b0, {28'h0, SEL_L1_DATA}, good(32'h0));
    access(K_SEL, 1'b1, 32'h0, good({28'h0, SEL_L1_INSTR}));
    access(K_SIZE, 1'b1, 32'h0, good(32'h201f_e00a));
    access(K_SIZE, 1'b0, 32'h0, good(32'h701f_e00a));
    apb(1'b0, 32'h0000_0010, 32'h0, rd, err);
    chk("pslverr high", 32'h1, {31'h0, err});
    apb(1'b0, 32'h0000_0002, 32'h0, rd, err);
    chk("pslverr misaligned", 32'h1, {31'h0, err});
    // Second reset in mid-run, then the bank must answer as before
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    access(K_ISA4, 1'b0, 32'h0, good(32'h1001_1142));
    // Selection is back at level one data after reset
    access(K_SIZE, 1'b0, 32'h0, good(32'h701f_e00a));
    access(K_SEL | 16'h8000, 1'b0, {28'h0, SEL_L2}, good(32'h0));
    access(K_SIZE, 1'b0, 32'h0, good(32'h71ff_e07a));
    apb(1'b0, {28'h0, APB_CMD}, 32'h0, rd, err);
    chk("cmd readback", 32'h0000_0012, rd);
    chk("pending answers", 32'h0, exp_q.size());
    wrap_up();
  end
endmodule // isa_and_cache_id_registers_tb
`default_nettype wire

//--- logic/core_id_ctrl.sv
// APB-programmed controller that issues coprocessor accesses on the link
`timescale 1ns/1ps
`default_nettype none
module core_id_ctrl
  import id_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  // Link
  cp_link_if.core_end      link
);

  logic        apb_wr;
  logic        mapped;
  logic [31:0] cmd_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        busy_q;
  logic        undef_q;
  logic        done_q;
  logic        start;

  assign mapped    = (paddr_i[31:4] == 28'h0) && (paddr_i[1:0] == 2'h0);
  assign apb_wr    = psel_i && penable_i && pwrite_i && mapped;
  // Commands arriving while busy are dropped, not queued
  assign start     = apb_wr && (paddr_i[3:0] == APB_CMD) && !busy_q;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_comb begin
    prdata_o = WORD_RESET;
    if (psel_i && mapped && !pwrite_i) begin
      case (paddr_i[3:0])
        APB_CMD:    prdata_o = cmd_q;
        APB_WDATA:  prdata_o = wdata_q;
        APB_STATUS: prdata_o = {29'h0, done_q, undef_q, busy_q};
        APB_RDATA:  prdata_o = rdata_q;
        default:    prdata_o = WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_q   <= WORD_RESET;
      wdata_q <= WORD_RESET;
    end else begin
      if (start)
        cmd_q <= pwdata_i;
      if (apb_wr && paddr_i[3:0] == APB_WDATA && !busy_q)
        wdata_q <= pwdata_i;
    end
  end

  // Request held until acknowledged
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      undef_q <= 1'b0;
      rdata_q <= WORD_RESET;
    end else if (start) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q && link.rsp_ack) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b1;
      undef_q <= link.rsp_undef;
      if (!cmd_q[CMD_WRITE])
        rdata_q <= link.rsp_rdata;
    end
  end

  // Encoding fields taken straight from the command word
  assign link.req_valid     = busy_q;
  assign link.req_write     = cmd_q[CMD_WRITE];
  assign link.req_priv      = cmd_q[CMD_PRIV];
  assign link.req_nonsecure = cmd_q[CMD_NONSEC];
  assign link.req_opc1      = cmd_q[CMD_OPC1+2:CMD_OPC1];
  assign link.req_crn       = cmd_q[CMD_CRN+3:CMD_CRN];
  assign link.req_crm       = cmd_q[CMD_CRM+3:CMD_CRM];
  assign link.req_opc2      = cmd_q[CMD_OPC2+2:CMD_OPC2];
  assign link.req_wdata     = wdata_q;

endmodule // core_id_ctrl
`default_nettype wire

//--- logic/cp_link_if.sv
// Coprocessor read/write link between core and identification registers
`timescale 1ns/1ps
`default_nettype none
interface cp_link_if;
  logic        req_valid;
  logic        req_write;
  logic        req_priv;
  logic        req_nonsecure;
  logic [2:0]  req_opc1;
  logic [3:0]  req_crn;
  logic [3:0]  req_crm;
  logic [2:0]  req_opc2;
  logic [31:0] req_wdata;
  logic        rsp_ack;
  logic        rsp_undef;
  logic [31:0] rsp_rdata;

  modport device_end (
    input  req_valid, req_write, req_priv, req_nonsecure,
    input  req_opc1, req_crn, req_crm, req_opc2, req_wdata,
    output rsp_ack, rsp_undef, rsp_rdata
  );
  modport core_end (
    output req_valid, req_write, req_priv, req_nonsecure,
    output req_opc1, req_crn, req_crm, req_opc2, req_wdata,
    input  rsp_ack, rsp_undef, rsp_rdata
  );
endinterface
`default_nettype wire

//--- logic/id_regs_pkg.sv
// Shared constants and types for the identification register link
package id_regs_pkg;

  // Register selector encodings on the coprocessor link
  localparam logic [3:0] CRN_ID        = 4'h0;
  localparam logic [3:0] CRM_ISA       = 4'h2;
  localparam logic [3:0] CRM_CACHE     = 4'h0;
  localparam logic [2:0] OPC1_ISA      = 3'h0;
  localparam logic [2:0] OPC1_CACHE    = 3'h1;
  localparam logic [2:0] OPC1_SEL      = 3'h2;
  localparam logic [2:0] OPC2_ISA3     = 3'h3;
  localparam logic [2:0] OPC2_ISA4     = 3'h4;
  localparam logic [2:0] OPC2_ISA5     = 3'h5;
  localparam logic [2:0] OPC2_SIZE     = 3'h0;
  localparam logic [2:0] OPC2_LEVEL    = 3'h1;
  localparam logic [2:0] OPC2_SEL      = 3'h0;

  // Instruction attribute 3 fields
  localparam logic [3:0] ENV_EXTN      = 4'h1;
  localparam logic [3:0] TRUE_NOP      = 4'h1;
  localparam logic [3:0] LOW_MOVE      = 4'h1;
  localparam logic [3:0] TABLE_BRANCH  = 4'h1;
  localparam logic [3:0] SYNC_PRIM     = 4'h2;
  localparam logic [3:0] SUPV_CALL     = 4'h1;
  localparam logic [3:0] SIMD_FIELD    = 4'h0;
  localparam logic [3:0] SATURATE      = 4'h1;
  // Instruction attribute 4 fields
  localparam logic [3:0] SWAP_LOCK     = 4'h1;
  localparam logic [3:0] MPROFILE_PSR  = 4'h0;
  localparam logic [3:0] SYNC_FRAC     = 4'h0;
  localparam logic [3:0] BARRIER       = 4'h1;
  localparam logic [3:0] MONITOR_CALL  = 4'h1;
  localparam logic [3:0] WRITEBACK     = 4'h1;
  localparam logic [3:0] UNPRIV_LDST   = 4'h4;
  localparam logic [3:0] SHIFTED_ACC   = 4'h2;

  // Cache size information field layout
  localparam int WT_BIT   = 31;
  localparam int WB_BIT   = 30;
  localparam int RA_BIT   = 29;
  localparam int WA_BIT   = 28;
  localparam int SETS_LSB = 13;
  localparam int WAYS_LSB = 3;
  localparam logic [9:0]  WAYS_TWO     = 10'h001;
  localparam logic [9:0]  WAYS_SIXTEEN = 10'h00f;
  localparam logic [2:0]  LINE_16W     = 3'h2;
  localparam logic [14:0] SETS_L1      = 15'h00ff;
  localparam logic [14:0] SETS_L2_512K = 15'h01ff;
  localparam logic [14:0] SETS_L2_1M   = 15'h03ff;
  localparam logic [14:0] SETS_L2_2M   = 15'h07ff;
  localparam logic [14:0] SETS_L2_4M   = 15'h0fff;

  // Cache level information fields
  localparam logic [2:0] LVL_UNIF_UP   = 3'h1;
  localparam logic [2:0] LVL_COHERENCY = 3'h2;
  localparam logic [2:0] LVL_UNIF_IS   = 3'h1;
  localparam logic [2:0] CTYPE_SPLIT   = 3'h3;
  localparam logic [2:0] CTYPE_UNIFIED = 3'h4;
  localparam logic [2:0] CTYPE_NONE    = 3'h0;

  // Cache selection layout and reset
  localparam logic [3:0] SEL_RESET     = 4'h0;
  localparam logic [3:0] SEL_L1_DATA   = 4'h0;
  localparam logic [3:0] SEL_L1_INSTR  = 4'h1;
  localparam logic [3:0] SEL_L2        = 4'h2;

  // Level-2 size strap codes
  typedef enum logic [1:0] {
    L2_512K  = 2'h0,
    L2_1024K = 2'h1,
    L2_2048K = 2'h2,
    L2_4096K = 2'h3
  } l2_size_t;

  // Controller register map on APB
  localparam logic [3:0] APB_CMD    = 4'h0;
  localparam logic [3:0] APB_WDATA  = 4'h4;
  localparam logic [3:0] APB_STATUS = 4'h8;
  localparam logic [3:0] APB_RDATA  = 4'hc;
  localparam int CMD_WRITE   = 0;
  localparam int CMD_PRIV    = 1;
  localparam int CMD_NONSEC  = 2;
  localparam int CMD_OPC1    = 4;
  localparam int CMD_CRN     = 8;
  localparam int CMD_CRM     = 12;
  localparam int CMD_OPC2    = 16;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_UNDEF  = 1;
  localparam int STAT_DONE   = 2;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

endpackage

//--- logic/isa_cache_id_regs.sv
// Identification register bank: instruction set and cache geometry
// Operation
// - Attribute 3 upper four fields read one
// - Sync fields read two and zero
// - Supervisor call and saturate fields read one
// - Attribute 3 at opc1 0, c0, c2, 3
// - Attribute 4 swap one, M-profile zero
// - Barrier, monitor call, writeback read one
// - Attribute 4 at opc1 0, c0, c2, 4
// - Attribute 5 reads zero, ignores writes
// - Size info per cache, chosen by selection
// - Size info policy, sets, ways, line fields
// - Ways codes two and sixteen, line 16
// - Selections zero and one give L1 values
// - Selection two follows configured L2 size
// - Size info at opc1 1, c0, c0, 0
// - Level info reports unification and coherency levels
// - Level info cache types, top bits zero
// - Level info at opc1 1, c0, c0, 1
// - Read-only and not banked except selection, privileged only
// - Selection holds level and instruction flag
`timescale 1ns/1ps
`default_nettype none
module isa_cache_id_regs
  import id_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // Configuration strap, level-2 size
  input  wire logic [1:0] l2_size_i,
  // Link
  cp_link_if.device_end   link
);

  typedef enum {
    TGT_ISA3,
    TGT_ISA4,
    TGT_ISA5,
    TGT_SIZE,
    TGT_LEVEL,
    TGT_SEL,
    TGT_NONE
  } target_t;

  typedef enum {
    ST_IDLE,
    ST_ANSWER
  } state_t;

  state_t      state_q;
  target_t     target;
  logic [1:0]  l2_meta_q;
  logic [1:0]  l2_sync_q;
  l2_size_t    l2_size_q;
  logic [3:0]  sel_sec_q;
  logic [3:0]  sel_nsec_q;
  logic [3:0]  sel_cur;
  logic [31:0] size_info;
  logic [31:0] read_val;
  logic        undef;
  logic        taken;
  logic        ack_q;
  logic        undef_q;
  logic [31:0] rdata_q;

  // Maps a link encoding onto one of the implemented registers
  function automatic target_t decode(input logic [2:0] opc1,
                                     input logic [3:0] crn,
                                     input logic [3:0] crm,
                                     input logic [2:0] opc2);
    target_t t;
    t = TGT_NONE;
    if (crn == CRN_ID) begin
      if (opc1 == OPC1_ISA && crm == CRM_ISA) begin
        if (opc2 == OPC2_ISA3)
          t = TGT_ISA3;
        else if (opc2 == OPC2_ISA4)
          t = TGT_ISA4;
        else if (opc2 == OPC2_ISA5)
          t = TGT_ISA5;
      end else if (opc1 == OPC1_CACHE && crm == CRM_CACHE) begin
        if (opc2 == OPC2_SIZE)
          t = TGT_SIZE;
        else if (opc2 == OPC2_LEVEL)
          t = TGT_LEVEL;
      end else if (opc1 == OPC1_SEL && crm == CRM_CACHE &&
                   opc2 == OPC2_SEL) begin
        t = TGT_SEL;
      end
    end
    return t;
  endfunction

  // Builds a size word from its policy bits and geometry
  function automatic logic [31:0] size_word(input logic wt,
                                            input logic wb,
                                            input logic ra,
                                            input logic wa,
                                            input logic [14:0] sets,
                                            input logic [9:0] ways);
    logic [31:0] w;
    w = WORD_RESET;
    w[WT_BIT] = wt;
    w[WB_BIT] = wb;
    w[RA_BIT] = ra;
    w[WA_BIT] = wa;
    w[SETS_LSB +: 15] = sets;
    w[WAYS_LSB +: 10] = ways;
    w[2:0] = LINE_16W;
    return w;
  endfunction

  localparam logic [31:0] ISA3_VALUE = {ENV_EXTN, TRUE_NOP, LOW_MOVE,
                                        TABLE_BRANCH, SYNC_PRIM, SUPV_CALL,
                                        SIMD_FIELD, SATURATE};
  localparam logic [31:0] ISA4_VALUE = {SWAP_LOCK, MPROFILE_PSR, SYNC_FRAC,
                                        BARRIER, MONITOR_CALL, WRITEBACK,
                                        UNPRIV_LDST, SHIFTED_ACC};
  localparam logic [31:0] LEVEL_VALUE = {2'h0, LVL_UNIF_UP, LVL_COHERENCY,
                                         LVL_UNIF_IS, CTYPE_NONE, CTYPE_NONE,
                                         CTYPE_NONE, CTYPE_NONE, CTYPE_NONE,
                                         CTYPE_UNIFIED, CTYPE_SPLIT};

  // Strap is asynchronous to the core clock, so it is synchronised
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      l2_meta_q <= 2'h0;
      l2_sync_q <= 2'h0;
    end else begin
      l2_meta_q <= l2_size_i;
      l2_sync_q <= l2_meta_q;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      l2_size_q <= L2_512K;
    else
      l2_size_q <= l2_size_t'(l2_sync_q);
  end

  assign target = decode(link.req_opc1, link.req_crn, link.req_crm,
                         link.req_opc2);
  // Selection is banked by security state; size info itself is not
  assign sel_cur = link.req_nonsecure ? sel_nsec_q : sel_sec_q;

  always_comb begin
    case (sel_cur)
      SEL_L1_DATA:  size_info = size_word(1'b0, 1'b1, 1'b1, 1'b1,
                                          SETS_L1, WAYS_TWO);
      SEL_L1_INSTR: size_info = size_word(1'b0, 1'b0, 1'b1, 1'b0,
                                          SETS_L1, WAYS_TWO);
      SEL_L2: begin
        case (l2_size_q)
          L2_512K:  size_info = size_word(1'b0, 1'b1, 1'b1, 1'b1,
                                          SETS_L2_512K, WAYS_SIXTEEN);
          L2_1024K: size_info = size_word(1'b0, 1'b1, 1'b1, 1'b1,
                                          SETS_L2_1M, WAYS_SIXTEEN);
          L2_2048K: size_info = size_word(1'b0, 1'b1, 1'b1, 1'b1,
                                          SETS_L2_2M, WAYS_SIXTEEN);
          default:  size_info = size_word(1'b0, 1'b1, 1'b1, 1'b1,
                                          SETS_L2_4M, WAYS_SIXTEEN);
        endcase
      end
      // Reserved selections read as zero
      default: size_info = WORD_RESET;
    endcase
  end

  always_comb begin
    read_val = WORD_RESET;
    undef    = 1'b0;
    if (!link.req_priv) begin
      undef = 1'b1;
    end else begin
      case (target)
        TGT_ISA3: begin
          read_val = ISA3_VALUE;
          undef    = link.req_write;
        end
        TGT_ISA4: begin
          read_val = ISA4_VALUE;
          undef    = link.req_write;
        end
        // Reserved register: reads zero, writes dropped quietly
        TGT_ISA5:  read_val = WORD_RESET;
        TGT_SIZE: begin
          read_val = size_info;
          undef    = link.req_write;
        end
        TGT_LEVEL: begin
          read_val = LEVEL_VALUE;
          undef    = link.req_write;
        end
        TGT_SEL:   read_val = {28'h0, sel_cur};
        default:   undef = 1'b1;
      endcase
    end
  end

  assign taken = (state_q == ST_IDLE) && link.req_valid;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      state_q <= ST_IDLE;
    else begin
      case (state_q)
        ST_IDLE:   if (taken) state_q <= ST_ANSWER;
        ST_ANSWER: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Only level and instruction flag are kept; upper bits ignored
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_sec_q  <= SEL_RESET;
      sel_nsec_q <= SEL_RESET;
    end else if (taken && !undef && link.req_write && target == TGT_SEL) begin
      if (link.req_nonsecure)
        sel_nsec_q <= link.req_wdata[3:0];
      else
        sel_sec_q <= link.req_wdata[3:0];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q   <= 1'b0;
      undef_q <= 1'b0;
      rdata_q <= WORD_RESET;
    end else begin
      ack_q <= taken;
      if (taken) begin
        undef_q <= undef;
        // Undefined accesses return zero data
        rdata_q <= (undef || link.req_write) ? WORD_RESET : read_val;
      end
    end
  end

  assign link.rsp_ack   = ack_q;
  assign link.rsp_undef = undef_q;
  assign link.rsp_rdata = rdata_q;

endmodule // isa_cache_id_regs
`default_nettype wire
